/* hw/safety_controller.sv */
// Machine-side safety controller: evaluates both channels, restart
// interlock and contactor feedback, and drives the two contactors.
// Assumes all inputs are synchronous to sys_clk; feedback inputs are high
// while the positively guided contactor rests de-energized.
//
// How it works
// - Sensor turns both outputs on when clear.
// - Sensor turns both outputs off when interrupted.
// - Internal sensor fault forces an output off.
// - Any channel off forces the safe state.
// - Channels are sampled separately, never merged.
// - Disagreement beyond discrepancy time is detected.
// - After interruption, restart needs reset button press.
// - Operating mode change also requires reset.
// - Sensor lacks interlock and feedback monitoring.
// - Auxiliary contacts must show release after off.
// - Start allowed only with both contactors released.
// - Reset press with outputs on energizes both.
// - Outputs losing voltage drops both contactors.
// - Cross or short circuit on channels locks.
// - Contactor failing to release is detected.
// - Indicator shows red when a beam blocked.
`timescale 1ns/1ps
`include "monitor_defines.svh"

module safety_controller
#(
   parameter logic [`CNT_W-1:0] EDM_CYCLES = `CNT_W'(`EDM_CYCLES)
)
(
   // Clock and reset
   input  wire logic             sys_clk,
   input  wire logic             rst_n,
   // Link from the sensor
   safety_link_if.controller     link,
   // Operator and machine mode
   input  wire logic             reset_button,
   input  wire logic             mode_change,
   // Contactor auxiliary feedback
   input  wire logic             contactor_one_released,
   input  wire logic             contactor_two_released,
   // Contactor drives
   output logic                  contactor_one_drive,
   output logic                  contactor_two_drive,
   // Status
   output logic                  machine_run,
   output logic                  restart_wait,
   output logic                  fault_lock,
   output monitor_pkg::cause_type fault_cause
);
   import monitor_pkg::*;

   // ----------------------------------------------------------------------
   // Channel capture
   // ----------------------------------------------------------------------
   // Each channel has its own register so a fault on one line can never
   // be masked by the other one.
   logic chan_a_q;
   logic chan_b_q;

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         chan_a_q <= `OUT_OFF;
         chan_b_q <= `OUT_OFF;
      end
      else
      begin
         chan_a_q <= link.safety_output_a;
         chan_b_q <= link.safety_output_b;
      end
   end

   // ----------------------------------------------------------------------
   // Decoding
   // ----------------------------------------------------------------------
   logic btn_q;
   logic both_on;
   logic any_off;
   logic reset_press;
   logic both_released;
   logic disc_fault;
   logic edm_expired;
   logic fault_now;
   logic start_ok;

   assign both_on       = (chan_a_q == `OUT_ON) & (chan_b_q == `OUT_ON);
   assign any_off       = ~both_on;
   // Only the press edge counts, so a held button cannot restart alone.
   assign reset_press   = reset_button & ~btn_q;
   assign both_released = contactor_one_released
                        & contactor_two_released;
   assign start_ok      = reset_press & both_on
                        & both_released;
   assign fault_now     = disc_fault | edm_expired;

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         btn_q <= 1'b1;
      else
         btn_q <= reset_button;
   end

   // ----------------------------------------------------------------------
   // Discrepancy and cross-circuit watch
   // ----------------------------------------------------------------------
   // A cross or short circuit leaves one line stuck while the other one
   // switches, which shows here as a lasting disagreement.
   channel_discrepancy u_disc
   (
      .sys_clk        (sys_clk),
      .rst_n          (rst_n),
      .chan_a         (chan_a_q),
      .chan_b         (chan_b_q),
      .mismatch_fault (disc_fault)
   );

   // ----------------------------------------------------------------------
   // Contactor feedback monitor
   // ----------------------------------------------------------------------
   logic              drive_q;
   logic              drive_d;
   logic [`CNT_W-1:0] edm_cnt_q;
   logic [`CNT_W-1:0] edm_cnt_d;
   logic              edm_pending;

   // While the drive is off, both contactors must report release within
   // the feedback time; a welded contact keeps the count running.
   assign edm_pending = ~drive_q & ~both_released;
   assign edm_expired = (edm_cnt_q >= EDM_CYCLES);
   assign edm_cnt_d   = !edm_pending ? '0 :
                        edm_expired ? edm_cnt_q
                                    : edm_cnt_q + `CNT_W'(1);

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         edm_cnt_q <= '0;
      else
         edm_cnt_q <= edm_cnt_d;
   end

   // ----------------------------------------------------------------------
   // Interlock state machine
   // ----------------------------------------------------------------------
   ctrl_state_type state_q;
   ctrl_state_type state_d;

   always_comb
   begin
      state_d = state_q;
      unique case (state_q)
         ST_ARMED:
         begin
            // Clearing the beams alone never restarts the machine.
            if (fault_now)
               state_d = ST_FAULT;
            else if (start_ok && !mode_change)
               state_d = ST_RUN;
         end
         ST_RUN:
         begin
            if (fault_now)
               state_d = ST_FAULT;
            else if (any_off)
               state_d = ST_ARMED;
            else if (mode_change)
               state_d = ST_ARMED;
         end
         ST_FAULT:
         begin
            // Leaving needs the cause gone and a fresh operator reset.
            if (!fault_now && reset_press)
               state_d = ST_ARMED;
         end
         default:
            state_d = ST_FAULT;
      endcase
   end

   assign drive_d = (state_d == ST_RUN);

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_q <= ST_ARMED;
         drive_q <= 1'b0;
      end
      else
      begin
         state_q <= state_d;
         drive_q <= drive_d;
      end
   end

   // ----------------------------------------------------------------------
   // Sticky fault causes
   // ----------------------------------------------------------------------
   // A new fault in the clearing cycle wins over the clear.
   cause_type cause_q;
   cause_type cause_d;
   logic      cause_clear;

   assign cause_clear         = (state_q == ST_FAULT) && (state_d == ST_ARMED);
   assign cause_d.discrepancy = disc_fault
                              | (cause_q.discrepancy & ~cause_clear);
   assign cause_d.contactor   = edm_expired
                              | (cause_q.contactor & ~cause_clear);

   // ----------------------------------------------------------------------
   // Output registers
   // ----------------------------------------------------------------------
   logic one_q;
   logic two_q;
   logic run_q;
   logic wait_q;
   logic lock_q;

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         one_q   <= 1'b0;
         two_q   <= 1'b0;
         run_q   <= 1'b0;
         wait_q  <= 1'b1;
         lock_q  <= 1'b0;
         cause_q <= '0;
      end
      else
      begin
         one_q   <= drive_d;
         two_q   <= drive_d;
         run_q   <= drive_d;
         wait_q  <= (state_d == ST_ARMED);
         lock_q  <= (state_d == ST_FAULT);
         cause_q <= cause_d;
      end
   end

   assign contactor_one_drive = one_q;
   assign contactor_two_drive = two_q;
   assign machine_run         = run_q;
   assign restart_wait        = wait_q;
   assign fault_lock          = lock_q;
   assign fault_cause         = cause_q;

endmodule : safety_controller

/* hw/monitor_defines.svh */
// Named constants shared by both ends of the dual-channel safety link.
// Assumes a single 250 MHz clock at both ends.
`ifndef MONITOR_DEFINES_SVH
`define MONITOR_DEFINES_SVH

// ----------------------------------------------------------------------
// Clock
// ----------------------------------------------------------------------
`define CLK_PERIOD_NS   4

// ----------------------------------------------------------------------
// Beams and output levels
// ----------------------------------------------------------------------
`define BEAM_COUNT      4
`define OUT_ON          1'b1
`define OUT_OFF         1'b0

// ----------------------------------------------------------------------
// Timing (longest times, rounded down to whole cycles)
// ----------------------------------------------------------------------
`define CNT_W           16
`define DISC_TIME_NS    10000
`define DISC_CYCLES     ((`DISC_TIME_NS) / (`CLK_PERIOD_NS))
`define EDM_TIME_NS     8000
`define EDM_CYCLES      ((`EDM_TIME_NS) / (`CLK_PERIOD_NS))

`endif

/* hw/monitor_pkg.sv */
// Types shared by both ends of the dual-channel safety link.
// Assumes monitor_defines.svh supplies the numeric constants.
package monitor_pkg;

   // ----------------------------------------------------------------------
   // Controller states, Gray coded along armed -> run -> fault
   // ----------------------------------------------------------------------
   typedef enum logic [1:0]
   {
      ST_ARMED = 2'h0,
      ST_RUN   = 2'h1,
      ST_FAULT = 2'h3
   } ctrl_state_type;

   // ----------------------------------------------------------------------
   // Sticky fault causes
   // ----------------------------------------------------------------------
   typedef struct packed
   {
      logic discrepancy;
      logic contactor;
   } cause_type;

endpackage : monitor_pkg

/* hw/safety_link_if.sv */
// The two redundant safety switching outputs between sensor and controller.
// Assumes the testbench instantiates it and binds both ends.
`timescale 1ns/1ps

interface safety_link_if;

   logic safety_output_a;
   logic safety_output_b;

   modport sensor
   (
      output safety_output_a,
      output safety_output_b
   );

   modport controller
   (
      input  safety_output_a,
      input  safety_output_b
   );

endinterface : safety_link_if

/* hw/beam_sensor.sv */
// Receiver end: drives the two safety switching outputs and the indicator.
// Assumes beam and fault inputs are synchronous to sys_clk.
`timescale 1ns/1ps
`include "monitor_defines.svh"

module beam_sensor
(
   // Clock and reset
   input  wire logic                   sys_clk,
   input  wire logic                   rst_n,
   // Optical front end
   input  wire logic [`BEAM_COUNT-1:0] beam_clear,
   input  wire logic                   internal_fault,
   // Link to the controller
   safety_link_if.sensor               link,
   // Output indicator
   output logic                        indicator_red,
   output logic                        indicator_green
);
   import monitor_pkg::*;

   // ----------------------------------------------------------------------
   // Switch-off decision
   // ----------------------------------------------------------------------
   logic [`BEAM_COUNT-1:0] beam_blocked;
   logic                   any_blocked;
   logic                   permit;
   logic                   out_a_q;
   logic                   out_b_q;
   logic                   red_q;
   logic                   green_q;

   genvar gi;
   generate
      for (gi = 0; gi < `BEAM_COUNT; gi++)
      begin : g_beam
         assign beam_blocked[gi] = ~beam_clear[gi];
      end
   endgenerate

   assign any_blocked = |beam_blocked;
   // Only an entirely clear light path with no fault lets the outputs on.
   assign permit      = ~any_blocked & ~internal_fault;

   // ----------------------------------------------------------------------
   // Output stage
   // ----------------------------------------------------------------------
   // A fault drops both channels, which covers the at-least-one demand.
   // Restart interlock and contactor monitoring are absent here on purpose.
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         out_a_q <= `OUT_OFF;
         out_b_q <= `OUT_OFF;
      end
      else
      begin
         out_a_q <= permit ? `OUT_ON : `OUT_OFF;
         out_b_q <= permit ? `OUT_ON : `OUT_OFF;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         red_q   <= 1'b1;
         green_q <= 1'b0;
      end
      else
      begin
         red_q   <= ~permit;
         green_q <= permit;
      end
   end

   assign link.safety_output_a = out_a_q;
   assign link.safety_output_b = out_b_q;
   assign indicator_red        = red_q;
   assign indicator_green      = green_q;

endmodule : beam_sensor

/* hw/channel_discrepancy.sv */
// Times how long the two safety channels disagree.
// Assumes both channel inputs are already registered in sys_clk.
`timescale 1ns/1ps
`include "monitor_defines.svh"

module channel_discrepancy
(
   // Clock and reset
   input  wire logic sys_clk,
   input  wire logic rst_n,
   // Channels
   input  wire logic chan_a,
   input  wire logic chan_b,
   // Result
   output logic      mismatch_fault
);
   import monitor_pkg::*;

   logic [`CNT_W-1:0] cnt_q;
   logic [`CNT_W-1:0] cnt_d;
   logic              differ;
   logic              expired;
   logic              fault_q;

   assign differ  = chan_a ^ chan_b;
   assign expired = (cnt_q >= `CNT_W'(`DISC_CYCLES));
   // Saturate so a long stuck channel cannot wrap back to a clean count.
   assign cnt_d   = !differ ? '0 :
                    expired ? cnt_q : cnt_q + `CNT_W'(1);

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cnt_q   <= '0;
         fault_q <= 1'b0;
      end
      else
      begin
         cnt_q   <= cnt_d;
         fault_q <= differ & expired;
      end
   end

   assign mismatch_fault = fault_q;

endmodule : channel_discrepancy

/* testbench/safety_link_sva.sv */
// Concurrent checks on the main safety link and the two ends around it.
// Assumes tb_top instantiates it beside the main link; one clock domain.
`timescale 1ns/1ps
`include "monitor_defines.svh"

module safety_link_sva
(
   // Clock and reset
   input  wire logic                   sys_clk,
   input  wire logic                   rst_n,
   // Sensor side
   input  wire logic [`BEAM_COUNT-1:0] beam_clear,
   input  wire logic                   internal_fault,
   input  wire logic                   indicator_red,
   // Link
   input  wire logic                   safety_output_a,
   input  wire logic                   safety_output_b,
   // Controller side
   input  wire logic                   reset_button,
   input  wire logic                   mode_change,
   input  wire logic                   contactor_one_released,
   input  wire logic                   contactor_two_released,
   input  wire logic                   contactor_one_drive,
   input  wire logic                   contactor_two_drive,
   input  wire logic                   machine_run,
   input  wire logic                   fault_lock
);
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rst_n);

   sequence s_stopped;
      !contactor_one_drive && !contactor_two_drive && !machine_run;
   endsequence

   sequence s_press;
      !reset_button ##1 reset_button;
   endsequence

   AST_ON_WHEN_CLEAR: assert property (
      (&beam_clear && !internal_fault) |=> safety_output_a && safety_output_b)
      else $error("outputs not on with all beams clear");
   AST_OFF_WHEN_BLOCKED: assert property (
      !(&beam_clear) |=> !safety_output_a && !safety_output_b)
      else $error("outputs not off with a beam blocked");
   AST_FAULT_DROPS: assert property (
      internal_fault |=> !(safety_output_a && safety_output_b))
      else $error("both outputs on during a sensor fault");
   AST_RED_WHEN_BLOCKED: assert property (
      !(&beam_clear) |=> indicator_red)
      else $error("indicator not red with a beam blocked");
   AST_STOP_ON_A: assert property (
      !safety_output_a |-> ##2 s_stopped)
      else $error("channel a off did not stop the machine");
   AST_STOP_ON_B: assert property (
      !safety_output_b |-> ##2 s_stopped)
      else $error("channel b off did not stop the machine");
   AST_START_ON_PRESS: assert property (
      $rose(machine_run) |-> $past(reset_button) && !$past(reset_button, 2))
      else $error("machine started without a button press");
   AST_START_RELEASED: assert property (
      $rose(machine_run)
      |-> $past(contactor_one_released && contactor_two_released))
      else $error("machine started with a contactor not released");
   AST_MODE_BLOCKS: assert property (mode_change |=> s_stopped)
      else $error("machine running after a mode change");
   AST_LOCK_SAFE: assert property (fault_lock |-> s_stopped)
      else $error("machine running while locked");
   AST_DRIVES_PAIRED: assert property (
      contactor_one_drive == contactor_two_drive
      && machine_run == contactor_one_drive)
      else $error("contactor drives disagree");

   cover property (s_press ##1 machine_run);

endmodule : safety_link_sva

/* testbench/tb_top.sv */
// Bench: sensor and controller on the main link, plus a second controller
// on a link that the bench drives itself to break the pairing.
// Assumes the design files and monitor_defines.svh are on the include path.
`timescale 1ns/1ps
`include "monitor_defines.svh"

module tb_top;
   import monitor_pkg::*;

   localparam logic [`CNT_W-1:0] EDM_SHORT = `CNT_W'(8);

   logic                   sys_clk;
   logic                   rst_n;
   logic [`BEAM_COUNT-1:0] beam_clear;
   logic                   internal_fault;
   logic                   reset_button;
   logic                   mode_change;
   logic                   stuck_two;
   logic                   indicator_red;
   logic                   indicator_green;
   logic                   drive_one;
   logic                   drive_two;
   logic                   released_one;
   logic                   released_two;
   logic                   machine_run;
   logic                   restart_wait;
   logic                   fault_lock;
   cause_type              fault_cause;
   logic                   f_run;
   logic                   f_lock;
   cause_type              f_cause;
   logic [1:0]             chans;
   logic [1:0]             drives;
   int                     n_mismatch;
   int                     samples_checked;

   safety_link_if link_main ();
   safety_link_if link_fault ();

   // A welded contactor two is modelled by holding its release contact low.
   assign released_one = !drive_one;
   assign released_two = !drive_two && !stuck_two;
   assign chans        = {link_main.safety_output_a,
                          link_main.safety_output_b};
   assign drives       = {drive_one, drive_two};

   beam_sensor beam_sensor_i (.sys_clk(sys_clk), .rst_n(rst_n),
      .beam_clear(beam_clear), .internal_fault(internal_fault),
      .link(link_main), .indicator_red(indicator_red),
      .indicator_green(indicator_green));

   safety_controller #(.EDM_CYCLES(EDM_SHORT)) safety_controller_i (
      .sys_clk(sys_clk), .rst_n(rst_n), .link(link_main),
      .reset_button(reset_button), .mode_change(mode_change),
      .contactor_one_released(released_one),
      .contactor_two_released(released_two),
      .contactor_one_drive(drive_one), .contactor_two_drive(drive_two),
      .machine_run(machine_run), .restart_wait(restart_wait),
      .fault_lock(fault_lock), .fault_cause(fault_cause));

   safety_controller #(.EDM_CYCLES(EDM_SHORT)) safety_controller_i2 (
      .sys_clk(sys_clk), .rst_n(rst_n), .link(link_fault),
      .reset_button(reset_button), .mode_change(1'b0),
      .contactor_one_released(1'b1), .contactor_two_released(1'b1),
      .contactor_one_drive(), .contactor_two_drive(),
      .machine_run(f_run), .restart_wait(), .fault_lock(f_lock),
      .fault_cause(f_cause));

   safety_link_sva safety_link_sva_i (.sys_clk(sys_clk), .rst_n(rst_n),
      .beam_clear(beam_clear), .internal_fault(internal_fault),
      .indicator_red(indicator_red),
      .safety_output_a(link_main.safety_output_a),
      .safety_output_b(link_main.safety_output_b),
      .reset_button(reset_button), .mode_change(mode_change),
      .contactor_one_released(released_one),
      .contactor_two_released(released_two),
      .contactor_one_drive(drive_one), .contactor_two_drive(drive_two),
      .machine_run(machine_run), .fault_lock(fault_lock));

   initial
   begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end

   // ----------------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------------
   task automatic cyc(input int n);
      repeat (n) @(negedge sys_clk);
   endtask : cyc

   task automatic end_of_test();
      $display("Checks %0d, mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : end_of_test

   task automatic chk_pair(input logic [1:0] got, input logic [1:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk_pair

   task automatic chk_cause(input cause_type got, input cause_type exp);
      samples_checked++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk_cause

   // A lock that never comes ends the run rather than hanging it.
   task automatic wait_lock(input bit far, input int limit, output int t);
      t = 0;
      while (((far ? f_lock : fault_lock) !== 1'b1) && t < limit)
      begin
         cyc(1);
         t++;
      end
      if (t >= limit)
      begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
         end_of_test();
      end
   endtask : wait_lock

   task automatic press();
      reset_button = 1'b1;
      cyc(1);
      reset_button = 1'b0;
      cyc(1);
   endtask : press

   // ----------------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------------
   task automatic t_beams();
      for (int i = 0; i < `BEAM_COUNT; i++)
      begin
         beam_clear = ~(`BEAM_COUNT'(1) << i);
         cyc(1);
         chk_pair(chans, 2'h0);
         chk_pair({indicator_red, indicator_green}, 2'h2);
         beam_clear = '1;
         cyc(1);
         chk_pair(chans, 2'h3);
         chk_pair({indicator_red, indicator_green}, 2'h1);
      end
      internal_fault = 1'b1;
      cyc(1);
      chk_pair({&chans, indicator_red}, 2'h1);
      internal_fault = 1'b0;
      cyc(1);
   endtask : t_beams

   task automatic t_restart();
      cyc(3);
      chk_pair(drives, 2'h0);
      chk_pair({restart_wait, machine_run}, 2'h2);
      press();
      chk_pair(drives, 2'h3);
      beam_clear[0] = 1'b0;
      cyc(3);
      chk_pair(drives, 2'h0);
      beam_clear[0] = 1'b1;
      cyc(6);
      chk_pair({drives[1], restart_wait}, 2'h1);
      press();
      chk_pair(drives, 2'h3);
   endtask : t_restart

   task automatic t_mode();
      mode_change = 1'b1;
      cyc(2);
      chk_pair(drives, 2'h0);
      press();
      chk_pair(drives, 2'h0);
      mode_change = 1'b0;
      cyc(1);
      press();
      chk_pair(drives, 2'h3);
   endtask : t_mode

   task automatic t_edm();
      int t;
      stuck_two = 1'b1;
      beam_clear[0] = 1'b0;
      cyc(3);
      chk_pair(drives, 2'h0);
      beam_clear[0] = 1'b1;
      cyc(2);
      press();
      chk_pair({drives[0], fault_lock}, 2'h0);
      wait_lock(1'b0, 40, t);
      chk_pair({t >= 3, t <= 9}, 2'h3);
      chk_cause(fault_cause, 2'h1);
      press();
      chk_pair({fault_lock, drives[0]}, 2'h2);
      stuck_two = 1'b0;
      cyc(1);
      press();
      chk_pair({fault_lock, restart_wait}, 2'h1);
      chk_cause(fault_cause, 2'h0);
   endtask : t_edm

   // Channel b shorted to 0 V while a stays on: a cross-circuit.
   task automatic t_disc();
      int t;
      press();
      chk_pair({f_run, f_lock}, 2'h2);
      link_fault.safety_output_b = 1'b0;
      cyc(2);
      chk_pair({f_run, f_lock}, 2'h0);
      wait_lock(1'b1, `DISC_CYCLES + 20, t);
      chk_pair({t >= `DISC_CYCLES, t <= `DISC_CYCLES + 6}, 2'h3);
      chk_cause(f_cause, 2'h2);
      press();
      chk_pair({f_lock, f_run}, 2'h2);
      link_fault.safety_output_b = 1'b1;
      cyc(2);
      press();
      chk_pair({f_lock, f_run}, 2'h0);
      chk_cause(f_cause, 2'h0);
   endtask : t_disc

   initial
   begin
      n_mismatch = 0;
      samples_checked = 0;
      rst_n = 1'b0;
      beam_clear = '1;
      internal_fault = 1'b0;
      reset_button = 1'b0;
      mode_change = 1'b0;
      stuck_two = 1'b0;
      link_fault.safety_output_a = 1'b1;
      link_fault.safety_output_b = 1'b1;
      cyc(6);
      rst_n = 1'b1;
      cyc(2);
      t_beams();
      t_restart();
      t_mode();
      t_edm();
      t_disc();
      end_of_test();
   end

endmodule : tb_top
